// *** alert_pkg.sv ***
// Purpose: Shared constants, register map and carrier types of the limit alert monitor.
// Assumes: Twelve-bit conversion codes, nine monitored channels and one 40 MHz system clock.
// Notes: Channels 0-3 are voltage inputs, 4-5 current sense, 6-7 external diodes, 8 the internal sensor.
package alert_pkg;
	// ****************************************************************
	// Sizes and codes
	// ****************************************************************
	localparam int NUM_CH = 9;
	localparam logic [3:0] FIRST_TEMP_CH = 4'h6;
	localparam logic [3:0] FIRST_DIODE_CH = 4'h6;
	localparam logic [3:0] LAST_DIODE_CH = 4'h7;
	localparam logic [11:0] CODE_MAX = 12'hfff;
	localparam logic [11:0] CODE_MIN = 12'h000;
	localparam logic [11:0] HYST_RECORD = 12'hfff;
	localparam logic [11:0] HYST_RST_VOLT = 12'h008;
	localparam logic [11:0] HYST_RST_TEMP = 12'h020;
	localparam int DIODE_FLAG_BIT = 11;

	// Conversion rate in autocycle operation, kept for reference by software and tests.
	localparam int CLK_MHZ = 40;
	localparam int CONV_PERIOD_US = 50;
	localparam int CONV_PERIOD_CYC = CONV_PERIOD_US * CLK_MHZ;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] ADDR_RESULT = 8'h01;
	localparam logic [7:0] ADDR_STAT_A = 8'h04;
	localparam logic [7:0] ADDR_STAT_B = 8'h05;
	localparam logic [7:0] ADDR_STAT_C = 8'h06;
	localparam logic [7:0] ADDR_CONFIG = 8'h09;
	localparam logic [7:0] ADDR_HYST_VOLTAGE_INPUT_ZERO = 8'h0d;
	localparam logic [7:0] ADDR_LIMIT_BASE = 8'h0b;
	localparam logic [7:0] LIM_STRIDE = 8'h03;
	localparam logic [7:0] LIM_SPAN = 8'h1b;
	localparam logic [1:0] FIELD_LOW = 2'h0;
	localparam logic [1:0] FIELD_HIGH = 2'h1;
	localparam logic [1:0] FIELD_HYST = 2'h2;
	localparam int CFG_FLAG_EN_BIT = 1;
	localparam int CFG_PIN_EN_BIT = 2;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam int STAT_B_OVR_LSB = 4;
	localparam int STAT_C_OPEN_BIT = 7;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	typedef struct packed {
		logic [3:0] chan;
		logic [11:0] data;
	} conv_t;

	typedef struct packed {
		logic flag;
		logic [3:0] chan;
		logic [11:0] data;
	} result_t;

	typedef struct packed {
		logic [11:0] hyst;
		logic [11:0] high;
		logic [11:0] low;
	} lim_word_t;

	// Power-up hysteresis: temperature channels get a wider band.
	function automatic logic [11:0] hyst_reset(input int ch);
		return (ch >= int'(FIRST_TEMP_CH)) ? HYST_RST_TEMP : HYST_RST_VOLT;
	endfunction
endpackage

// *** limit_store.sv ***
// Purpose: Per-channel store of lower limit, upper limit and hysteresis words.
// Assumes: One write port with field enables and two registered read ports.
// Notes: Reads of a channel beyond the last one return zero.
`timescale 1ns/10ps
module limit_store import alert_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic wr_en_i,
	input wire logic [3:0] wr_chan_i,
	input wire logic [2:0] wr_field_i,
	input wire lim_word_t wr_word_i,
	input wire logic [3:0] rd_a_chan_i,
	output lim_word_t rd_a_word_o,
	input wire logic [3:0] rd_b_chan_i,
	output lim_word_t rd_b_word_o
);
	lim_word_t mem [NUM_CH];

	// Power-up contents put each channel at the widest window.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < NUM_CH; i++) begin
				mem[i] <= '{hyst: hyst_reset(i), high: CODE_MAX, low: CODE_MIN};
			end
		end else if (wr_en_i && (int'(wr_chan_i) < NUM_CH)) begin
			if (wr_field_i[FIELD_LOW]) mem[wr_chan_i].low <= wr_word_i.low;
			if (wr_field_i[FIELD_HIGH]) mem[wr_chan_i].high <= wr_word_i.high;
			if (wr_field_i[FIELD_HYST]) mem[wr_chan_i].hyst <= wr_word_i.hyst;
		end
	end

	// Both read ports are registered so the output is a clean flop.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_a_word_o <= '0;
			rd_b_word_o <= '0;
		end else begin
			rd_a_word_o <= (int'(rd_a_chan_i) < NUM_CH) ? mem[rd_a_chan_i] : '0;
			rd_b_word_o <= (int'(rd_b_chan_i) < NUM_CH) ? mem[rd_b_chan_i] : '0;
		end
	end
endmodule

// *** alert_monitor.sv ***
// Purpose: Limit checking, hysteresis release, min/max recording and alert reporting for conversions.
// Assumes: Conversions and register accesses are synchronous to sys_clk_i; the serial slave sits outside.
// Notes: A conversion is judged one cycle after it arrives, once its limit word is read.
`timescale 1ns/10ps
module alert_monitor import alert_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic conv_valid_i,
	input wire conv_t conv_i,
	input wire logic [1:0] overrange_i,
	input wire logic [1:0] diode_open_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	output logic reg_ready_o,
	output logic reg_rvalid_o,
	output logic [15:0] reg_rdata_o,
	output result_t result_o,
	output logic alert_pin_o
);
	// ****************************************************************
	// Address decoding
	// ****************************************************************
	// Returns {hit, field, channel} for an address in the limit block.
	function automatic logic [6:0] lim_decode(input logic [7:0] addr);
		logic [7:0] idx;
		logic [7:0] ch;
		logic [7:0] fld;
		idx = addr - ADDR_LIMIT_BASE;
		ch = idx / LIM_STRIDE;
		fld = idx % LIM_STRIDE;
		return {(addr >= ADDR_LIMIT_BASE) && (idx < LIM_SPAN), fld[1:0], ch[3:0]};
	endfunction

	conv_t conv_reg;
	logic conv_pend_reg;
	logic [17:0] lim_stat_reg;
	logic [17:0] lim_stat_next;
	logic [1:0] ovr_stat_reg;
	logic [1:0] ovr_stat_next;
	logic open_stat_reg;
	logic open_stat_next;
	logic [7:0] cfg_reg;
	logic [7:0] cfg_next;
	result_t result_next;
	logic alert_pin_next;
	logic rd_pend_reg;
	logic [7:0] rd_addr_reg;
	logic [15:0] read_mux;
	lim_word_t cur_word;
	lim_word_t host_word;

	wire [6:0] wr_dec = lim_decode(reg_addr_i);
	wire [6:0] rd_dec = lim_decode(rd_addr_reg);
	wire [6:0] rd_now_dec = lim_decode(reg_addr_i);

	// ****************************************************************
	// Limit comparison of the pending conversion
	// ****************************************************************
	// Thirteen-bit sums keep a large hysteresis from wrapping, so a band near full scale never releases.
	wire rec_mode = (cur_word.hyst == HYST_RECORD);
	wire low_trip = conv_reg.data < cur_word.low;
	wire high_trip = conv_reg.data > cur_word.high;
	wire low_rel = {1'b0, conv_reg.data} >= ({1'b0, cur_word.low} + {1'b0, cur_word.hyst});
	wire high_rel = ({1'b0, conv_reg.data} + {1'b0, cur_word.hyst}) <= {1'b0, cur_word.high};
	wire judge = conv_pend_reg && !rec_mode;

	// A recorder update takes the store's write port, so host writes wait one cycle.
	wire rec_wr = conv_pend_reg && rec_mode && (low_trip || high_trip);
	wire host_wr = reg_wr_i && reg_ready_o;

	// Host clears: writing ones to a status register, or a configuration write that sets both enable bits.
	wire clr_all = host_wr && (reg_addr_i == ADDR_CONFIG) && reg_wdata_i[CFG_FLAG_EN_BIT]
		&& reg_wdata_i[CFG_PIN_EN_BIT];
	wire wr_a = host_wr && (reg_addr_i == ADDR_STAT_A);
	wire wr_b = host_wr && (reg_addr_i == ADDR_STAT_B);
	wire wr_c = host_wr && (reg_addr_i == ADDR_STAT_C);
	wire [17:0] lim_clr = {18{clr_all}} | {wr_c ? reg_wdata_i[5:0] : 6'h00,
		wr_b ? reg_wdata_i[3:0] : 4'h0, wr_a ? reg_wdata_i[7:0] : 8'h00};
	wire [1:0] ovr_clr = {2{clr_all}} | (wr_b ? reg_wdata_i[STAT_B_OVR_LSB +: 2] : 2'h0);
	wire open_clr = clr_all || (wr_c && reg_wdata_i[STAT_C_OPEN_BIT]);

	// Per-channel set and release terms; each channel reads only its own word.
	logic [17:0] lim_set;
	logic [17:0] lim_rel;
	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++) begin : g_chan
			wire hit = judge && (conv_reg.chan == 4'(c));
			assign lim_set[2 * c] = hit && low_trip;
			assign lim_set[2 * c + 1] = hit && high_trip;
			assign lim_rel[2 * c] = hit && low_rel;
			assign lim_rel[2 * c + 1] = hit && high_rel;
		end
	endgenerate

	// Set wins over both release and host clear, so no event is lost.
	assign lim_stat_next = lim_set | (lim_stat_reg & ~lim_rel & ~lim_clr);
	assign ovr_stat_next = overrange_i | (ovr_stat_reg & ~ovr_clr);
	assign open_stat_next = (|diode_open_i) | (open_stat_reg & ~open_clr);
	wire any_next = (|lim_stat_next) || (|ovr_stat_next) || open_stat_next;
	assign cfg_next = (host_wr && (reg_addr_i == ADDR_CONFIG)) ? reg_wdata_i[7:0] : cfg_reg;
	assign alert_pin_next = cfg_reg[CFG_PIN_EN_BIT] && any_next;
	assign result_next = conv_pend_reg ?
		result_t'{flag: cfg_reg[CFG_FLAG_EN_BIT] && any_next, chan: conv_reg.chan, data: conv_reg.data} :
		result_o;
	assign reg_ready_o = !rec_wr;

	// ****************************************************************
	// Limit store
	// ****************************************************************
	wire [2:0] host_field = 3'h1 << wr_dec[5:4];
	wire [2:0] rec_field = {1'b0, high_trip, low_trip};
	limit_store u_store (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.wr_en_i(rec_wr || (host_wr && wr_dec[6])),
		.wr_chan_i(rec_wr ? conv_reg.chan : wr_dec[3:0]),
		.wr_field_i(rec_wr ? rec_field : host_field),
		.wr_word_i(rec_wr ? lim_word_t'({conv_reg.data, conv_reg.data, conv_reg.data}) :
			lim_word_t'({3{reg_wdata_i[11:0]}})),
		.rd_a_chan_i(conv_i.chan),
		.rd_a_word_o(cur_word),
		.rd_b_chan_i(rd_now_dec[3:0]),
		.rd_b_word_o(host_word)
	);

	// ****************************************************************
	// Register read path
	// ****************************************************************
	// Diode channels show the open-circuit state in bit 11 of both limit words.
	wire [3:0] rd_chan = rd_dec[3:0];
	wire rd_diode = (rd_chan >= FIRST_DIODE_CH) && (rd_chan <= LAST_DIODE_CH) && (rd_dec[5:4] != FIELD_HYST);
	wire [3:0] diode_idx = rd_chan - FIRST_DIODE_CH;
	wire [11:0] rd_field = (rd_dec[5:4] == FIELD_LOW) ? host_word.low :
		(rd_dec[5:4] == FIELD_HIGH) ? host_word.high : host_word.hyst;
	wire [11:0] rd_limit = rd_diode ?
		{~diode_open_i[diode_idx[0]], rd_field[DIODE_FLAG_BIT - 1:0]} : rd_field;

	always_comb begin
		if (rd_dec[6]) begin
			read_mux = {4'h0, rd_limit};
		end else if (rd_addr_reg == ADDR_RESULT) begin
			read_mux = {result_o.flag, result_o.chan[2:0], result_o.data};
		end else if (rd_addr_reg == ADDR_STAT_A) begin
			read_mux = {8'h00, lim_stat_reg[7:0]};
		end else if (rd_addr_reg == ADDR_STAT_B) begin
			read_mux = {10'h000, ovr_stat_reg, lim_stat_reg[11:8]};
		end else if (rd_addr_reg == ADDR_STAT_C) begin
			read_mux = {8'h00, open_stat_reg, 1'b0, lim_stat_reg[17:12]};
		end else if (rd_addr_reg == ADDR_CONFIG) begin
			read_mux = {8'h00, cfg_reg};
		end else begin
			read_mux = 16'h0000;
		end
	end

	// ****************************************************************
	// State registers
	// ****************************************************************
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			conv_reg <= '0;
			conv_pend_reg <= 1'b0;
			lim_stat_reg <= '0;
			ovr_stat_reg <= '0;
			open_stat_reg <= 1'b0;
			cfg_reg <= CFG_RESET;
			result_o <= '0;
			alert_pin_o <= 1'b0;
		end else begin
			conv_reg <= conv_i;
			conv_pend_reg <= conv_valid_i;
			lim_stat_reg <= lim_stat_next;
			ovr_stat_reg <= ovr_stat_next;
			open_stat_reg <= open_stat_next;
			cfg_reg <= cfg_next;
			result_o <= result_next;
			alert_pin_o <= alert_pin_next;
		end
	end

	// Read answers two cycles after the request, from a flop.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_pend_reg <= 1'b0;
			rd_addr_reg <= '0;
			reg_rvalid_o <= 1'b0;
			reg_rdata_o <= '0;
		end else begin
			rd_pend_reg <= reg_rd_i;
			rd_addr_reg <= reg_addr_i;
			reg_rvalid_o <= rd_pend_reg;
			reg_rdata_o <= rd_pend_reg ? read_mux : reg_rdata_o;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	low_trip_a: assert property (judge && low_trip |=> lim_stat_reg[{$past(conv_reg.chan), 1'b0}])
		else $error("Low limit violation did not raise its alert.");
	high_trip_a: assert property (judge && high_trip |=> lim_stat_reg[{$past(conv_reg.chan), 1'b1}])
		else $error("High limit violation did not raise its alert.");
	release_a: assert property (judge && low_rel && !low_trip |=> !lim_stat_reg[{$past(conv_reg.chan), 1'b0}])
		else $error("In-range result did not release the low alert.");
	hyst_hold_a: assert property (judge && !low_trip && !low_rel && !host_wr
		&& lim_stat_reg[{conv_reg.chan, 1'b0}] |=> lim_stat_reg[{$past(conv_reg.chan), 1'b0}])
		else $error("Low alert released inside the hysteresis band.");
	overrange_hold_a: assert property (ovr_stat_reg[0] && !ovr_clr[0] |=> ovr_stat_reg[0])
		else $error("Overrange alert dropped without a host clear.");
	pin_gate_a: assert property (!cfg_reg[CFG_PIN_EN_BIT] |=> !alert_pin_o)
		else $error("Alert pin asserted while disabled.");
	recorder_quiet_a: assert property (conv_pend_reg && rec_mode && !host_wr |=> $stable(lim_stat_reg))
		else $error("Recorder channel changed the alert status.");
	flag_report_a: assert property (conv_pend_reg && cfg_reg[CFG_FLAG_EN_BIT] && (|lim_set) |=> result_o.flag)
		else $error("Result flag missing after a limit violation.");
	clear_bit_a: assert property (wr_a && reg_wdata_i[0] && !lim_set[0] |=> !lim_stat_reg[0])
		else $error("Write of one did not clear the alert bit.");
	read_latency_a: assert property (reg_rd_i |-> ##2 reg_rvalid_o)
		else $error("Register read answer not on time.");

	trip_c: cover property (judge && high_trip ##1 alert_pin_o);
	record_c: cover property (rec_wr ##1 reg_wr_i && !reg_ready_o);
	release_c: cover property (lim_stat_reg[0] ##1 !lim_stat_reg[0]);
endmodule

// *** alert_host.sv ***
// Purpose: Host model that writes and reads the monitor registers one access at a time.
// Assumes: Strobes change just after a rising edge; reads answer within a few cycles.
// Notes: Released address and data lines show the inverse of the last value, never a stale copy.
`timescale 1ns/10ps
module alert_host (
	input wire logic sys_clk_i,
	input wire logic reg_ready_i,
	input wire logic reg_rvalid_i,
	input wire logic [15:0] reg_rdata_i,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [7:0] reg_addr_o,
	output logic [15:0] reg_wdata_o
);
	// ****
	// Access tasks
	// ****
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 16'h0000;
	end

	// A write is held until an edge that saw ready high, since a recorder update may refuse it.
	task automatic wr(input logic [7:0] addr, input logic [15:0] data);
		logic rdy;
		@(posedge sys_clk_i);
		reg_wr_o <= 1'b1;
		reg_addr_o <= addr;
		reg_wdata_o <= data;
		rdy = 1'b0;
		while (rdy !== 1'b1) begin
			@(negedge sys_clk_i);
			rdy = reg_ready_i;
			@(posedge sys_clk_i);
		end
		reg_wr_o <= 1'b0;
		reg_addr_o <= ~addr;
		reg_wdata_o <= ~data;
	endtask

	// A read strobe lasts one cycle; the data is taken when the valid pulse is seen.
	task automatic rd(input logic [7:0] addr, output logic [15:0] data);
		int n;
		@(posedge sys_clk_i);
		reg_rd_o <= 1'b1;
		reg_addr_o <= addr;
		@(posedge sys_clk_i);
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~addr;
		for (n = 0; n < 5 && reg_rvalid_i !== 1'b1; n++) begin
			@(posedge sys_clk_i);
			#1;
		end
		data = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 'x;
	endtask
endmodule

// *** test_alert_monitor.sv ***
// Purpose: Self-checking bench for the limit alert monitor.
// Assumes: The host model drives the register side; the bench drives conversions and fault inputs.
// Notes: Conversions are spaced so that no write meets a refused cycle by accident.
`timescale 1ns/10ps
module test_alert_monitor import alert_pkg::*; ();
	logic sys_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic conv_valid = 1'b0;
	conv_t conv = '0;
	logic [1:0] overrange = 2'h0;
	logic [1:0] diode_open = 2'h0;
	logic wr, rd, ready, rvalid, pin;
	logic [7:0] addr;
	logic [15:0] wdata, rdata;
	result_t result;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	logic [15:0] cfgs [3] = '{16'h0006, 16'h0002, 16'h0004};

	always #12.5 sys_clk_i = ~sys_clk_i;

	alert_monitor u_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .conv_valid_i(conv_valid), .conv_i(conv),
		.overrange_i(overrange), .diode_open_i(diode_open), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_ready_o(ready), .reg_rvalid_o(rvalid), .reg_rdata_o(rdata),
		.result_o(result), .alert_pin_o(pin));
	alert_host u_host (.sys_clk_i(sys_clk_i), .reg_ready_i(ready), .reg_rvalid_i(rvalid), .reg_rdata_i(rdata),
		.reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr), .reg_wdata_o(wdata));

	// ****
	// Helpers
	// ****
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// A hang is cut short well above the length of the whole sequence.
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			stop_test();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] exp, input string msg);
		logic [15:0] d;
		u_host.rd(a, d);
		chk(d, exp, msg);
	endtask

	// One conversion, then wait until its outcome has been registered.
	task automatic cv(input logic [3:0] ch, input logic [11:0] d);
		@(posedge sys_clk_i);
		conv_valid <= 1'b1;
		conv <= {ch, d};
		@(posedge sys_clk_i);
		conv_valid <= 1'b0;
		conv <= ~{ch, d};
		repeat (3) @(posedge sys_clk_i);
		#1;
	endtask

	function automatic logic [7:0] la(input int ch, input logic [1:0] f);
		return ADDR_LIMIT_BASE + LIM_STRIDE * 8'(ch) + 8'(f);
	endfunction

	// ****
	// Sequence
	// ****
	initial begin
		repeat (2) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		for (int ch = 0; ch < NUM_CH; ch++) begin
			rchk(la(ch, FIELD_LOW), (ch == 6 || ch == 7) ? 16'h0800 : 16'h0000, "low reset");
			rchk(la(ch, FIELD_HIGH), 16'h0fff, "high reset");
			rchk(la(ch, FIELD_HYST), (ch >= 6) ? 16'h0020 : 16'h0008, "hyst reset");
		end
		rchk(ADDR_HYST_VOLTAGE_INPUT_ZERO, 16'h0008, "hyst ch0");
		rchk(ADDR_CONFIG, 16'h0000, "config reset");
		rchk(8'hf0, 16'h0000, "unmapped");
		$display("test reset_values done");
		u_host.wr(la(0, FIELD_LOW), 16'h0100);
		u_host.wr(la(0, FIELD_HIGH), 16'h0200);
		u_host.wr(ADDR_CONFIG, 16'h0006);
		cv(0, 12'h0ff);
		chk({15'h0, pin}, 16'h0001, "pin on low");
		rchk(ADDR_STAT_A, 16'h0001, "low alert");
		cv(3, 12'h050);
		chk({15'h0, result.flag}, 16'h0001, "flag other");
		rchk(ADDR_RESULT, {1'b1, 3'h3, 12'h050}, "result word");
		cv(0, 12'h107);
		rchk(ADDR_STAT_A, 16'h0001, "inside band");
		cv(0, 12'h108);
		rchk(ADDR_STAT_A, 16'h0000, "low release");
		chk({15'h0, pin}, 16'h0000, "pin off");
		cv(0, 12'h201);
		rchk(ADDR_STAT_A, 16'h0002, "high alert");
		cv(0, 12'h1f9);
		rchk(ADDR_STAT_A, 16'h0002, "high band");
		cv(0, 12'h1f8);
		rchk(ADDR_STAT_A, 16'h0000, "high release");
		$display("test limits done");
		for (int i = 0; i < 3; i++) begin
			u_host.wr(ADDR_CONFIG, cfgs[i]);
			cv(0, 12'h0ff);
			chk({15'h0, pin}, {15'h0, cfgs[i][CFG_PIN_EN_BIT]}, "pin select");
			chk({15'h0, result.flag}, {15'h0, cfgs[i][CFG_FLAG_EN_BIT]}, "flag select");
		end
		u_host.wr(ADDR_STAT_A, 16'h0002);
		rchk(ADDR_STAT_A, 16'h0001, "other bit kept");
		u_host.wr(ADDR_STAT_A, 16'h00ff);
		rchk(ADDR_STAT_A, 16'h0000, "all cleared");
		$display("test routing done");
		u_host.wr(la(1, FIELD_HIGH), 16'h0200);
		u_host.wr(la(1, FIELD_HYST), 16'h0000);
		cv(1, 12'h201);
		rchk(ADDR_STAT_A, 16'h0008, "ch1 high");
		cv(1, 12'h200);
		rchk(ADDR_STAT_A, 16'h0000, "ch1 no band");
		u_host.wr(la(0, FIELD_HYST), 16'h077d);
		cv(0, 12'h0ff);
		cv(0, 12'h200);
		rchk(ADDR_STAT_A, 16'h0001, "never release");
		u_host.wr(ADDR_STAT_A, 16'h00ff);
		$display("test hysteresis done");
		u_host.wr(la(2, FIELD_LOW), 16'h0fff);
		u_host.wr(la(2, FIELD_HIGH), 16'h0000);
		u_host.wr(la(2, FIELD_HYST), 16'h0fff);
		cv(2, 12'h500);
		rchk(la(2, FIELD_LOW), 16'h0500, "min first");
		cv(2, 12'h300);
		cv(2, 12'h700);
		rchk(la(2, FIELD_LOW), 16'h0300, "min kept");
		rchk(la(2, FIELD_HIGH), 16'h0700, "max kept");
		rchk(ADDR_STAT_A, 16'h0000, "recorder quiet");
		// A write launched into the recorder update cycle must be refused once and then land.
		fork
			cv(2, 12'h200);
			begin
				@(posedge sys_clk_i);
				u_host.wr(la(1, FIELD_LOW), 16'h0010);
			end
			begin
				repeat (2) @(posedge sys_clk_i);
				#1;
				chk({15'h0, ready}, 16'h0000, "store busy");
			end
		join
		rchk(la(2, FIELD_LOW), 16'h0200, "min after busy");
		rchk(la(1, FIELD_LOW), 16'h0010, "write after busy");
		$display("test recorder done");
		@(posedge sys_clk_i);
		overrange <= 2'b01;
		repeat (2) @(posedge sys_clk_i);
		overrange <= 2'b00;
		diode_open <= 2'b01;
		repeat (4) @(posedge sys_clk_i);
		rchk(ADDR_STAT_B, 16'h0010, "overrange sticky");
		rchk(la(6, FIELD_LOW), 16'h0000, "diode open bit");
		@(posedge sys_clk_i);
		diode_open <= 2'b00;
		rchk(ADDR_STAT_C, 16'h0080, "open status");
		rchk(la(6, FIELD_LOW), 16'h0800, "diode closed");
		u_host.wr(ADDR_STAT_B, 16'h0020);
		rchk(ADDR_STAT_B, 16'h0010, "wrong bit");
		u_host.wr(ADDR_STAT_B, 16'h0010);
		rchk(ADDR_STAT_B, 16'h0000, "overrange clear");
		// Current and internal channels report in the other two status words.
		u_host.wr(la(4, FIELD_LOW), 16'h0100);
		u_host.wr(la(8, FIELD_HIGH), 16'h0100);
		cv(4, 12'h050);
		cv(8, 12'h101);
		rchk(ADDR_STAT_B, 16'h0001, "current low");
		rchk(ADDR_STAT_C, 16'h00a0, "internal high");
		u_host.wr(ADDR_CONFIG, 16'h0006);
		rchk(ADDR_STAT_B, 16'h0000, "config clear b");
		rchk(ADDR_STAT_C, 16'h0000, "config clear c");
		$display("test faults done");
		stop_test();
	end
endmodule
